// ===== logic/dosl_defs.svh
// constants for the dac output slew limiter: offsets, fields, resets, timing
// assumes inclusion by the package and the design module only
//
// Behaviour
// [R1] slew off: new code applied at once
// [R2] slew on: code stepped toward target
// [R3] 4-bit rate select, 64 kHz halving, 0.5 Hz
// [R4] 3-bit step select, 1 to 256 LSBs
// [R5] update rates divided from 13 MHz oscillator
// [R6] ramp time = change / (step x rate x lsb)
// [R7] slew on: every change ramps, clear included
// [R8] clear mid-ramp may skip other channels' ramps; here every channel keeps its own stepper and none skips its ramp
// [R9] rate identical for every output range
// [R10] host enables slew when hart rate matters
// [R11] clear active high, rising edge, clear code
// [R12] clear ignored unless channel clear permit set
// [R13] last step lands exactly on target
`ifndef DOSL_DEFS_SVH
`define DOSL_DEFS_SVH

// timing
`define DOSL_CLK_MHZ      5'd25
`define DOSL_OSC_MHZ      5'd13
`define DOSL_OSC_HZ       13000000
`define DOSL_BASE_HZ      64000
`define DOSL_BASE_DIV     (`DOSL_OSC_HZ / `DOSL_BASE_HZ)
`define DOSL_PRESC_W      18
`define DOSL_SLOW_EXP     5'd17

// register offsets inside one channel window
`define DOSL_CH_SHIFT     4
`define DOSL_TARGET_OFS   4'h0
`define DOSL_CLRCODE_OFS  4'h4
`define DOSL_CTRL_OFS     4'h8
`define DOSL_STAT_OFS     4'hc

// control fields
`define DOSL_RAMP_ON_BIT  0
`define DOSL_RATE_LSB     4
`define DOSL_INC_LSB      8
`define DOSL_PERMIT_BIT   12
// status fields
`define DOSL_BUSY_BIT     16

// reset values
`define DOSL_CODE_RST     16'h0000
`define DOSL_RATE_RST     4'h0
`define DOSL_INC_RST      3'h0

`endif

// ===== logic/dosl_pkg.sv
// types and lookup functions of the dac output slew limiter
// assumes dosl_defs.svh is on the include path
package dosl_pkg;
  `include "dosl_defs.svh"

  typedef struct packed {
    logic [15:0] target;
    logic [15:0] applied;
    logic [15:0] clr_code;
    logic        ramp_limit_on;
    logic [3:0]  ramp_update_rate_sel;
    logic [2:0]  ramp_increment_sel;
    logic        channel_clear_permit;
  } dosl_chan_type;

  // lsbs moved per update
  function automatic logic [15:0] dosl_step(input logic [2:0] sel);
    logic [15:0] s;
    s = 16'h0001;
    case (sel)
      3'h0:    s = 16'h0001;
      3'h1:    s = 16'h0002;
      3'h2:    s = 16'h0004;
      3'h3:    s = 16'h0010;
      3'h4:    s = 16'h0020;
      3'h5:    s = 16'h0040;
      3'h6:    s = 16'h0080;
      default: s = 16'h0100;
    endcase
    return s;
  endfunction : dosl_step

  // halvings of the 64 kHz base; top code skips to 0.5 Hz
  function automatic logic [4:0] dosl_rate_exp(input logic [3:0] sel);
    return (sel == 4'hf) ? `DOSL_SLOW_EXP : {1'b0, sel};
  endfunction : dosl_rate_exp
endpackage : dosl_pkg

// ===== logic/dosl_slew.sv
// per-channel digital slew limiter with apb register access
// channel n owns a 0x10 byte window: target, clear code, control, status
// assumes apb inputs and clear_in are synchronous to pclk
// assumes a single 25 mhz pclk; the 13 mhz oscillator rate is recreated from it
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "dosl_defs.svh"

module dosl_slew #(
  parameter int NCH = 4,
  parameter int AW  = 8
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [AW-1:0]        paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 clear_in,
  output logic      [NCH*16-1:0]    dac_code,
  output logic      [NCH-1:0]       ramp_busy
);
  import dosl_pkg::*;

  // channel index width; base divider end count (oscillator / 64 khz, truncated, minus one)
  localparam int CHW = (NCH > 1) ? $clog2(NCH) : 1;
  localparam logic [7:0] BASE_LAST = 8'(`DOSL_BASE_DIV - 1);

  // whole block state in one register; s_next is its combinational copy
  typedef struct packed {
    dosl_chan_type [NCH-1:0]   ch;
    logic [4:0]                osc_acc;
    logic [7:0]                base_cnt;
    logic [`DOSL_PRESC_W-1:0]  presc;
    logic                      clr_q;
    logic [31:0]               rdata;
  } dosl_state_type;

  dosl_state_type s_reg;
  dosl_state_type s_next;

  // address decode shared by read capture and write commit
  logic [CHW-1:0] a_ch;
  logic [3:0]     a_ofs;
  logic           a_hit;
  logic           wr_commit;
  logic           rd_setup;

  always_comb begin
    a_ch  = paddr[`DOSL_CH_SHIFT +: CHW];
    a_ofs = paddr[3:0];
    a_hit = (32'(a_ch) < NCH) && (paddr[1:0] == 2'b00);
    if (AW > `DOSL_CH_SHIFT + CHW) begin
      if ((paddr >> (`DOSL_CH_SHIFT + CHW)) != '0) begin
        a_hit = 1'b0;
      end
    end
  end

  // write commits in the access phase; read data is captured one edge earlier
  assign wr_commit = psel & penable & pwrite & a_hit;
  assign rd_setup  = psel & ~penable & ~pwrite;
  // zero wait states; unmapped access flagged in the access phase
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~a_hit;
  assign prdata    = s_reg.rdata;

  always_comb begin
    logic             osc_tick;
    logic             base_tick;
    logic             clr_edge;
    logic             upd;
    logic [5:0]       acc_sum;
    logic [4:0]       ex;
    logic [`DOSL_PRESC_W-1:0] mask;
    logic [15:0]      stp;
    dosl_chan_type    c;
    osc_tick  = 1'b0;
    base_tick = 1'b0;
    clr_edge  = 1'b0;
    upd       = 1'b0;
    acc_sum   = '0;
    ex        = '0;
    mask      = '0;
    stp       = '0;
    c         = '0;
    s_next    = s_reg;

    // 13 mhz oscillator rate recovered from pclk by a 13/25 accumulator
    // pattern repeats every 25 pclk cycles, so base spacing is 390 or 391 cycles
    acc_sum = {1'b0, s_reg.osc_acc} + {1'b0, `DOSL_OSC_MHZ}; // [R5]
    if (acc_sum >= {1'b0, `DOSL_CLK_MHZ}) begin
      osc_tick       = 1'b1;
      s_next.osc_acc = 5'(acc_sum - {1'b0, `DOSL_CLK_MHZ});
    end else begin
      s_next.osc_acc = acc_sum[4:0];
    end

    // integer divide of oscillator ticks down to the 64 khz base
    // the divide truncates, so the base runs a little above 64 khz
    if (osc_tick) begin
      if (s_reg.base_cnt == BASE_LAST) begin // [R5]
        s_next.base_cnt = '0;
        base_tick       = 1'b1;
      end else begin
        s_next.base_cnt = s_reg.base_cnt + 8'h01;
      end
    end
    // shared power-of-two prescaler, same for every output range
    if (base_tick) begin
      s_next.presc = s_reg.presc + `DOSL_PRESC_W'(1); // [R9]
    end

    // clear acts on the rising edge only
    s_next.clr_q = clear_in;
    clr_edge     = clear_in & ~s_reg.clr_q; // [R11]

    for (int i = 0; i < NCH; i++) begin
      // code r fires on every 2^r-th base tick, code 15 on every 2^17-th; phase is shared, not reset by writes,
      // so a new target waits at most one update period for its first step
      c   = s_reg.ch[i];
      ex  = dosl_rate_exp(c.ramp_update_rate_sel); // [R3]
      mask = (`DOSL_PRESC_W'(1) << ex) - `DOSL_PRESC_W'(1);
      upd = base_tick && ((s_reg.presc & mask) == '0);
      stp = dosl_step(c.ramp_increment_sel); // [R4]

      // stepping; distance shorter than one step lands on target
      // slew off bypasses the stepper, leaving the rate to the analog stage
      if (!c.ramp_limit_on) begin
        c.applied = c.target; // [R1]
      end else if (upd && (c.applied != c.target)) begin // [R2] [R6]
        if (c.target > c.applied) begin
          if ((c.target - c.applied) <= stp) begin
            c.applied = c.target; // [R13]
          end else begin
            c.applied = c.applied + stp;
          end
        end else begin
          if ((c.applied - c.target) <= stp) begin
            c.applied = c.target; // [R13]
          end else begin
            c.applied = c.applied - stp;
          end
        end
      end

      // software writes take effect at the access edge
      if (wr_commit && (32'(a_ch) == i)) begin
        case (a_ofs)
          `DOSL_TARGET_OFS:  c.target   = pwdata[15:0];
          `DOSL_CLRCODE_OFS: c.clr_code = pwdata[15:0];
          `DOSL_CTRL_OFS: begin
            c.ramp_limit_on        = pwdata[`DOSL_RAMP_ON_BIT];
            c.ramp_update_rate_sel = pwdata[`DOSL_RATE_LSB +: 4];
            c.ramp_increment_sel   = pwdata[`DOSL_INC_LSB +: 3];
            c.channel_clear_permit = pwdata[`DOSL_PERMIT_BIT];
          end
          default: ;
        endcase
      end

      // clear retargets the ramp, so it slews like any change
      // every permitted channel is retargeted in the same cycle with its own
      // stepper, so none skips its ramp even when another one is mid-ramp
      // applied after the software write, so clear wins a same-cycle target write
      if (clr_edge && c.channel_clear_permit) begin // [R12]
        c.target = c.clr_code; // [R7] [R11] [R8]
      end
      s_next.ch[i] = c;
    end

    // read data captured in setup, stable through the access phase
    // unmapped or reserved offsets read as zero; status has no write path
    if (rd_setup) begin
      s_next.rdata = 32'h0000_0000;
      if (a_hit) begin
        c = s_reg.ch[a_ch];
        case (a_ofs)
          `DOSL_TARGET_OFS:  s_next.rdata[15:0] = c.target;
          `DOSL_CLRCODE_OFS: s_next.rdata[15:0] = c.clr_code;
          `DOSL_CTRL_OFS: begin
            s_next.rdata[`DOSL_RAMP_ON_BIT]  = c.ramp_limit_on;
            s_next.rdata[`DOSL_RATE_LSB +: 4] = c.ramp_update_rate_sel;
            s_next.rdata[`DOSL_INC_LSB +: 3]  = c.ramp_increment_sel;
            s_next.rdata[`DOSL_PERMIT_BIT]   = c.channel_clear_permit;
          end
          `DOSL_STAT_OFS: begin
            s_next.rdata[15:0]           = c.applied;
            s_next.rdata[`DOSL_BUSY_BIT] = (c.applied != c.target);
          end
          default: ;
        endcase
      end
    end
  end

  // single state register; reset loads constants only
  // controls reset to slew off, fastest rate, 1 lsb step, clear not permitted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      for (int i = 0; i < NCH; i++) begin
        s_reg.ch[i].target               <= `DOSL_CODE_RST;
        s_reg.ch[i].applied              <= `DOSL_CODE_RST;
        s_reg.ch[i].clr_code             <= `DOSL_CODE_RST;
        s_reg.ch[i].ramp_update_rate_sel <= `DOSL_RATE_RST;
        s_reg.ch[i].ramp_increment_sel   <= `DOSL_INC_RST;
      end
    end else begin
      s_reg <= s_next;
    end
  end

  // applied codes straight from flops; busy flags decoded from them
  // busy is a compare of two flops, so it drops the cycle the ramp lands
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      dac_code[i*16 +: 16] = s_reg.ch[i].applied;
      ramp_busy[i]         = s_reg.ch[i].applied != s_reg.ch[i].target;
    end
  end
endmodule : dosl_slew

// ===== sim/dosl_slew_properties.sv
// checker of dosl_slew port relations; apb checks cover every address, code and clear checks channel 0 only
// assumes channel 0 registers sit at byte base 0
`timescale 1ns/1ps
module dosl_slew_properties #(
  parameter int NCH = 4,
  parameter int AW  = 8
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic [AW-1:0]     paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              clear_in,
  input wire logic [NCH*16-1:0] dac_code,
  input wire logic [NCH-1:0]    ramp_busy
);
  logic        on_reg, permit_reg, wr;
  logic [2:0]  inc_reg;
  logic [15:0] clr_reg, dac, stp;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // channel 0 settings shadowed at write commit
  assign wr  = psel & penable & pwrite;
  assign dac = dac_code[15:0];
  assign stp = 16'h0001 << ({1'b0, inc_reg} + {3'h0, inc_reg > 3'h2}); // no 8 lsb step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {on_reg, permit_reg, inc_reg, clr_reg} <= '0;
    end else if (wr && paddr == 8'h08) begin
      {permit_reg, inc_reg, on_reg} <= {pwdata[12], pwdata[10:8], pwdata[0]};
    end else if (wr && paddr == 8'h04) begin
      clr_reg <= pwdata[15:0];
    end
  end
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (psel && penable && paddr[7:6] != 2'h0 |-> pslverr)
    else $error("unmapped access without error");
  // a refused write leaves the last read data in place, so only reads are checked
  a_err_data_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  a_rdata_hold: assert property (psel && penable |=> $stable(prdata))
    else $error("read data changed after access");
  a_jump_direct: assert property (wr && paddr == 8'h00 && !on_reg |->
    ##2 dac == $past(pwdata[15:0], 2)) else $error("code not applied in one change");
  a_step_limit: assert property (on_reg && $past(on_reg) && $stable(inc_reg) |->
    (dac >= $past(dac) ? dac - $past(dac) : $past(dac) - dac) <= stp)
    else $error("step too large");
  a_idle_hold: assert property (!ramp_busy[0] && !wr && !clear_in |=> $stable(dac))
    else $error("code moved at target");
  a_clear_code: assert property ($rose(clear_in) && permit_reg && !on_reg |->
    ##2 dac == clr_reg) else $error("clear code not applied");
  a_clear_ignored: assert property ($rose(clear_in) && !permit_reg &&
    !ramp_busy[0] && !wr |=> $stable(dac) [*2])
    else $error("unpermitted channel moved on clear");
  c_target_write: cover property (wr && paddr == 8'h00);
  c_clear_ramp: cover property ($rose(clear_in) && permit_reg && on_reg);
  c_refused: cover property (pslverr);
endmodule : dosl_slew_properties

bind dosl_slew dosl_slew_properties #(.NCH(NCH), .AW(AW)) i_dosl_slew_properties (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .clear_in(clear_in), .dac_code(dac_code), .ramp_busy(ramp_busy));

// ===== sim/dosl_slew_test.sv
// testbench of dosl_slew: apb access, direct and ramped codes, clear
// assumes the default of four channels and the checker file alongside
`timescale 1ns/1ps
module dosl_slew_test;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, clear_in = 1'b0, pready, pslverr, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [63:0] dac_code;
  logic [3:0]  ramp_busy;
  logic [15:0] stp, tgt;
  int          failures = 0, cmp_count = 0, cyc = 0;
  always #20 pclk = ~pclk;
  dosl_slew i_dosl_slew (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clear_in(clear_in), .dac_code(dac_code), .ramp_busy(ramp_busy));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one apb transfer; request held until pready seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : xfer
  // follow one channel to its target; steps, busy, count and update spacing
  task automatic ramp(input int ch, input logic [15:0] t, input logic [15:0] s,
                      input int n, input int lo, input int hi);
    logic [15:0] prev, now;
    int          k, t1, cnt;
    prev = dac_code[ch*16 +: 16];
    now = prev;
    k = 0;
    t1 = 0;
    cnt = 0;
    repeat (20000) begin
      @(posedge pclk);
      // local count: the global cycle counter races this process at the edge
      cnt++;
      now = dac_code[ch*16 +: 16];
      if (now !== prev) begin
        k++;
        chk("step size", 32'h1, {31'h0, (now > prev ? now - prev : prev - now) <= s});
        chk("busy flag", {31'h0, now !== t}, {31'h0, ramp_busy[ch]});
        if (k == 2) chk("update gap", 32'h1, {31'h0, cnt - t1 >= lo && cnt - t1 <= hi});
        t1 = cnt;
        prev = now;
      end
      if (now === t && ramp_busy[ch] === 1'b0) break;
    end
    chk("final code", {16'h0, t}, {16'h0, now});
    chk("change count", n, k);
  endtask : ramp
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // hang guard, well above the roughly 40k cycles of the run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 80000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, 8'h08, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    xfer(1'b1, 8'h40, 32'h1);
    chk("unmapped error", 32'h1, {31'h0, err});
    xfer(1'b1, 8'h00, 32'h1234);
    ramp(0, 16'h1234, 16'hffff, 1, 0, 0);
    // every rate code stored; slow ones too long to run
    for (int r = 0; r < 16; r++) begin
      xfer(1'b1, 8'h28, 32'(r << 4));
      xfer(1'b0, 8'h28, 32'h0);
      chk("rate code", 32'(r << 4), rd);
    end
    // refused read must return zero although the last read was not
    xfer(1'b0, 8'h40, 32'h0);
    chk("unmapped read", 32'h0, rd);
    chk("read error", 32'h1, {31'h0, err});
    xfer(1'b1, 8'h04, 32'h0abc);
    xfer(1'b1, 8'h14, 32'h5555);
    xfer(1'b1, 8'h18, 32'h1000);
    clear_in <= 1'b1;
    ramp(1, 16'h5555, 16'hffff, 1, 0, 0);
    clear_in <= 1'b0;
    chk("unpermitted", 32'h1234, {16'h0, dac_code[15:0]});
    xfer(1'b0, 8'h1c, 32'h0);
    chk("status", 32'h0000_5555, rd);
    xfer(1'b1, 8'h08, 32'h1000);
    clear_in <= 1'b1;
    ramp(0, 16'h0abc, 16'hffff, 1, 0, 0);
    clear_in <= 1'b0;
    // each step code, two whole steps and one lsb more; spacing 390.4 cycles per base tick
    for (int k = 0; k < 8; k++) begin
      stp = (k < 3) ? 16'h1 << k : 16'h1 << (k + 1);
      xfer(1'b1, 8'h08, 32'((k << 8) | ((k / 2) << 4) | 1));
      tgt = dac_code[15:0] + 2 * stp + 16'h1;
      xfer(1'b1, 8'h00, {16'h0, tgt});
      ramp(0, tgt, stp, 3, 390 << (k / 2), 391 << (k / 2));
    end
    xfer(1'b1, 8'h04, 32'h0);
    xfer(1'b1, 8'h08, 32'h1701);
    clear_in <= 1'b1;
    ramp(0, 16'h0, 16'h100, (int'(dac_code[15:0]) + 255) / 256, 390, 391);
    clear_in <= 1'b0;
    report_and_stop();
  end
endmodule : dosl_slew_test
